//--- otp_map.svh
// otp_map.svh: timing, limit and code constants for the otp programming sequencer.
// assumes a 20 MHz clock; cycle counts are derived from the times below.
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH

`define OTP_CLK_MHZ 20
`define OTP_ADDR_W 17
`define OTP_DATA_W 8
`define OTP_TMR_W 12
// program pulse width, microseconds
`define OTP_PW_US 100
`define OTP_PW_MIN_US 95
`define OTP_PW_MAX_US 105
`define OTP_PW_CYC (`OTP_PW_US * `OTP_CLK_MHZ)
`define OTP_PW_MIN_CYC ((`OTP_PW_MIN_US * `OTP_CLK_MHZ))
`define OTP_PW_MAX_CYC ((`OTP_PW_MAX_US * `OTP_CLK_MHZ))
// address, data and supply setup / data hold, microseconds
`define OTP_SETUP_US 2
`define OTP_SETUP_CYC (`OTP_SETUP_US * `OTP_CLK_MHZ)
// data valid from output enable, nanoseconds, rounded up
`define OTP_TOE_NS 150
`define OTP_TOE_CYC ((`OTP_TOE_NS * `OTP_CLK_MHZ + 999) / 1000)
// output float after output enable high, nanoseconds, rounded up
`define OTP_TDFP_NS 130
`define OTP_TDFP_CYC ((`OTP_TDFP_NS * `OTP_CLK_MHZ + 999) / 1000)
// additional pulses allowed after the first one
`define OTP_MAX_RETRY 4'ha
`define OTP_FIFO_DEPTH 16
`define OTP_ZERO_ADDR 17'h0_0000
`define OTP_ADDR_ONE 17'h0_0001

`endif

//--- otp_pkg.sv
// otp_pkg.sv: types shared by the otp programming sequencer and its ports.
// assumes otp_map.svh supplies the widths.
`default_nettype none
`include "otp_map.svh"

package otp_pkg;

  typedef enum logic [3:0] {
    OTP_IDLE,
    OTP_ID_WAIT,
    OTP_LOAD,
    OTP_SETUP,
    OTP_PULSE,
    OTP_HOLD,
    OTP_VERIFY,
    OTP_FLOAT,
    OTP_RB_LOAD,
    OTP_RB_WAIT
  } otp_state_t;

  // pins toward the part; all strobes active low
  typedef struct packed {
    logic [`OTP_ADDR_W-1:0] addr;
    logic [`OTP_DATA_W-1:0] data;
    logic data_oe_n;
    logic chip_sel_n;
    logic out_en_n;
    logic program_pulse_n;
    logic id_high_level;
    logic vpp_high;
  } otp_pins_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
    logic fail;
    logic [`OTP_ADDR_W-1:0] fail_addr;
    logic id_valid;
    logic [`OTP_DATA_W-1:0] id_code;
  } otp_status_t;

endpackage
`default_nettype wire

//--- otp_seq.sv
// otp_seq.sv: source-byte fifo and the programmer that pulses, verifies and reads back an otp part.
// assumes pins reach the part through level shifters; data_i is synchronous to clock_i.
`timescale 1ns/10ps
`default_nettype none
`include "otp_map.svh"

module otp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  // full and empty are registered so the ports come straight from flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else if (ce_i) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
      if (push) begin
        mem[wr_ptr] <= in_data_i;
      end
    end
  end
endmodule

module otp_seq (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [`OTP_ADDR_W-1:0] last_addr_i,
  input wire logic id_req_i,
  input wire logic id_sel_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic [`OTP_DATA_W-1:0] src_data_i,
  input wire logic [`OTP_DATA_W-1:0] data_i,
  output var otp_pkg::otp_pins_t pins_o,
  output var otp_pkg::otp_status_t status_o
);
  import otp_pkg::*;

  otp_state_t state, next_state;
  otp_pins_t next_pins;
  otp_status_t next_status;
  logic [`OTP_TMR_W-1:0] tmr, next_tmr;
  logic [3:0] retry, next_retry;
  logic [`OTP_DATA_W-1:0] target, next_target;
  logic [`OTP_ADDR_W-1:0] last_addr, next_last_addr;
  logic go_next, next_go_next;
  logic rb_bad, next_rb_bad;
  logic fifo_valid, fifo_pop;
  logic [`OTP_DATA_W-1:0] fifo_data;

  otp_fifo #(
    .WIDTH(`OTP_DATA_W),
    .DEPTH(`OTP_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(src_ready_o),
    .in_data_i(src_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  function automatic otp_pins_t pins_idle(input otp_pins_t p);
    otp_pins_t r;
    r = p;
    r.data_oe_n = 1'b1;
    r.chip_sel_n = 1'b1;
    r.out_en_n = 1'b1;
    r.program_pulse_n = 1'b1;
    r.id_high_level = 1'b0;
    r.vpp_high = 1'b0;
    return r;
  endfunction

  function automatic logic [`OTP_TMR_W-1:0] cyc(input int n);
    return `OTP_TMR_W'(n);
  endfunction

  always_comb begin
    next_state = state;
    next_pins = pins_o;
    next_status = status_o;
    next_status.done = 1'b0;
    next_status.id_valid = 1'b0;
    next_tmr = (tmr != '0) ? `OTP_TMR_W'(tmr - 1'b1) : tmr;
    next_retry = retry;
    next_target = target;
    next_last_addr = last_addr;
    next_go_next = go_next;
    next_rb_bad = rb_bad;
    fifo_pop = 1'b0;
    unique case (state)
      OTP_IDLE: begin
        next_pins = pins_idle(pins_o);
        if (start_i) begin
          next_pins.addr = `OTP_ZERO_ADDR;
          next_pins.vpp_high = 1'b1;
          next_last_addr = last_addr_i;
          next_status.busy = 1'b1;
          next_status.pass = 1'b0;
          next_status.fail = 1'b0;
          next_rb_bad = 1'b0;
          next_state = OTP_LOAD;
        end else if (id_req_i) begin
          // raised id line plus code select on the lowest address bit
          next_pins.addr = {{(`OTP_ADDR_W-1){1'b0}}, id_sel_i};
          next_pins.id_high_level = 1'b1;
          next_pins.chip_sel_n = 1'b0;
          next_pins.out_en_n = 1'b0;
          next_tmr = cyc(`OTP_TOE_CYC);
          next_state = OTP_ID_WAIT;
        end
      end
      OTP_ID_WAIT: begin
        if (tmr == '0) begin
          next_status.id_code = data_i;
          next_status.id_valid = 1'b1;
          next_pins = pins_idle(pins_o);
          next_state = OTP_IDLE;
        end
      end
      OTP_LOAD: begin
        // stalls here until the source has supplied the byte
        if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_target = fifo_data;
          next_pins.data = fifo_data;
          next_pins.data_oe_n = 1'b0;
          next_pins.chip_sel_n = 1'b0;
          next_pins.out_en_n = 1'b1;
          next_retry = '0;
          next_tmr = cyc(`OTP_SETUP_CYC);
          next_state = OTP_SETUP;
        end
      end
      OTP_SETUP: begin
        if (tmr == '0) begin
          next_pins.program_pulse_n = 1'b0;
          next_tmr = cyc(`OTP_PW_CYC);
          next_state = OTP_PULSE;
        end
      end
      OTP_PULSE: begin
        if (tmr == '0) begin
          next_pins.program_pulse_n = 1'b1;
          next_tmr = cyc(`OTP_SETUP_CYC);
          next_state = OTP_HOLD;
        end
      end
      OTP_HOLD: begin
        // data released in the same edge that opens the read
        if (tmr == '0) begin
          next_pins.data_oe_n = 1'b1;
          next_pins.out_en_n = 1'b0;
          next_tmr = cyc(`OTP_TOE_CYC);
          next_state = OTP_VERIFY;
        end
      end
      OTP_VERIFY: begin
        if (tmr == '0) begin
          next_pins.out_en_n = 1'b1;
          next_tmr = cyc(`OTP_TDFP_CYC);
          next_state = OTP_FLOAT;
          if (data_i == target) begin
            next_go_next = 1'b1;
          end else if (retry == `OTP_MAX_RETRY) begin
            next_pins = pins_idle(pins_o);
            next_status.busy = 1'b0;
            next_status.fail = 1'b1;
            next_status.done = 1'b1;
            next_status.fail_addr = pins_o.addr;
            next_state = OTP_IDLE;
          end else begin
            next_go_next = 1'b0;
            next_retry = 4'(retry + 1'b1);
          end
        end
      end
      OTP_FLOAT: begin
        // wait for the part to float before driving the shared lines
        if (tmr == '0) begin
          if (!go_next) begin
            next_pins.data_oe_n = 1'b0;
            next_tmr = cyc(`OTP_SETUP_CYC);
            next_state = OTP_SETUP;
          end else if (pins_o.addr == last_addr) begin
            next_pins.vpp_high = 1'b0;
            next_pins.addr = `OTP_ZERO_ADDR;
            next_go_next = 1'b0;
            next_tmr = cyc(`OTP_SETUP_CYC);
            next_state = OTP_RB_LOAD;
          end else begin
            next_pins.addr = pins_o.addr + `OTP_ADDR_ONE;
            next_go_next = 1'b0;
            next_state = OTP_LOAD;
          end
        end
      end
      OTP_RB_LOAD: begin
        if (tmr == '0 && fifo_valid) begin
          fifo_pop = 1'b1;
          next_target = fifo_data;
          next_pins.chip_sel_n = 1'b0;
          next_pins.out_en_n = 1'b0;
          next_tmr = cyc(`OTP_TOE_CYC);
          next_state = OTP_RB_WAIT;
        end
      end
      OTP_RB_WAIT: begin
        if (tmr == '0) begin
          if (data_i != target && !rb_bad) begin
            next_rb_bad = 1'b1;
            next_status.fail_addr = pins_o.addr;
          end
          if (pins_o.addr == last_addr) begin
            next_pins = pins_idle(pins_o);
            next_status.busy = 1'b0;
            next_status.done = 1'b1;
            next_status.pass = !rb_bad && data_i == target;
            next_status.fail = rb_bad || data_i != target;
            next_state = OTP_IDLE;
          end else begin
            next_pins.addr = pins_o.addr + `OTP_ADDR_ONE;
            next_state = OTP_RB_LOAD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= OTP_IDLE;
      pins_o <= '{addr: '0, data: '0, data_oe_n: 1'b1, chip_sel_n: 1'b1, out_en_n: 1'b1,
                  program_pulse_n: 1'b1, id_high_level: 1'b0, vpp_high: 1'b0};
      status_o <= '0;
      tmr <= '0;
      retry <= '0;
      target <= '0;
      last_addr <= '0;
      go_next <= 1'b0;
      rb_bad <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      pins_o <= next_pins;
      status_o <= next_status;
      tmr <= next_tmr;
      retry <= next_retry;
      target <= next_target;
      last_addr <= next_last_addr;
      go_next <= next_go_next;
      rb_bad <= next_rb_bad;
    end
  end

  // helper counters read only by the checks below
  int pw_cnt;
  int pulses;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pw_cnt <= 0;
      pulses <= 0;
    end else if (ce_i) begin
      pw_cnt <= pins_o.program_pulse_n ? 0 : pw_cnt + 1;
      if (state == OTP_LOAD) begin
        pulses <= 0;
      end else if (state == OTP_SETUP && next_state == OTP_PULSE) begin
        pulses <= pulses + 1;
      end
    end
  end

  pulse_width_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(pins_o.program_pulse_n) |-> pw_cnt >= `OTP_PW_MIN_CYC && pw_cnt <= `OTP_PW_MAX_CYC)
    else $error("program pulse width out of range");
  start_addr_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state == OTP_LOAD && $past(state) == OTP_IDLE |-> pins_o.addr == '0)
    else $error("programming did not start at address zero");
  first_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(state == OTP_VERIFY) |-> pulses == int'(retry) + 1)
    else $error("verify read not preceded by exactly one pulse per try");
  retry_cap_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pulses <= int'(`OTP_MAX_RETRY) + 1 && retry <= `OTP_MAX_RETRY)
    else $error("too many pulses on one address");
  fail_stop_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(status_o.fail) && $past(state) == OTP_VERIFY |-> $past(retry) == `OTP_MAX_RETRY && state == OTP_IDLE)
    else $error("part failed before the retry limit");
  addr_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(pins_o.addr) && $past(state) == OTP_FLOAT |-> pins_o.addr == $past(pins_o.addr) + 1 || pins_o.addr == 0)
    else $error("address did not advance by one");
  readback_vpp_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == OTP_RB_LOAD || state == OTP_RB_WAIT) |-> !pins_o.vpp_high && pins_o.program_pulse_n)
    else $error("readback with programming supply raised");
  pass_src_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(status_o.pass) |-> $past(state) == OTP_RB_WAIT && !$past(rb_bad) && status_o.done)
    else $error("pass declared without full readback");
  id_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
    pins_o.id_high_level |-> state == OTP_ID_WAIT && pins_o.program_pulse_n && !pins_o.out_en_n)
    else $error("id level raised outside an identification read");
  verify_pins_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state == OTP_VERIFY |-> pins_o.program_pulse_n && !pins_o.chip_sel_n && !pins_o.out_en_n && pins_o.data_oe_n)
    else $error("verify read with wrong strobes");
  pulse_stable_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.program_pulse_n && !$past(pins_o.program_pulse_n) |-> $stable(pins_o.addr) && $stable(pins_o.data)
      && !pins_o.data_oe_n)
    else $error("address or data moved during the pulse");
  no_clash_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.data_oe_n |-> pins_o.out_en_n && $past(pins_o.out_en_n))
    else $error("data driven while part may drive");

  pass_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(status_o.pass));
  retry_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(state == OTP_VERIFY) && retry != '0);
  fail_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(status_o.fail));
  id_seen_c: cover property (@(posedge clock_i) disable iff (rst_i) status_o.id_valid);
endmodule
`default_nettype wire

//--- otp_part_model.sv
// otp_part_model.sv: behavioural otp part seen through the sequencer pins.
// assumes otp_pkg is compiled first and the part is sampled on the sequencer clock.
`timescale 1ns/10ps
`default_nettype none
module otp_part_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'hc3 // arbitrary value
) (
  input wire logic clock_i,
  input wire logic erase_i,
  input wire logic [3:0] need_i,
  input wire otp_pkg::otp_pins_t pins_i,
  output logic [7:0] dq_o
);
  import otp_pkg::*;
  logic [7:0] mem [32];
  logic [3:0] hits [32];
  logic [7:0] last = 8'h00;
  logic [12:0] low_cnt = 13'h0000;
  logic drive;
  logic [4:0] a;
  assign a = pins_i.addr[4:0];
  // outputs drive only while both selects are low; either one high floats them
  assign drive = !pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.program_pulse_n;
  always @(posedge clock_i) begin
    last <= dq_o;
    if (erase_i) begin
      foreach (mem[i]) begin
        mem[i] <= 8'hff;
        hits[i] <= 4'h0;
      end
      low_cnt <= 13'h0000;
    end else if (!pins_i.program_pulse_n && !pins_i.chip_sel_n && pins_i.vpp_high) begin
      low_cnt <= low_cnt + 13'h0001;
    end else begin
      // a pulse outside 95..105 us leaves the cell unchanged
      if (low_cnt >= 13'd1900 && low_cnt <= 13'd2100) begin
        hits[a] <= hits[a] + 4'h1;
        if (hits[a] + 4'h1 >= need_i) mem[a] <= pins_i.data;
      end
      low_cnt <= 13'h0000;
    end
  end
  always_comb begin
    // released lines toggle so a stale value is never mistaken for data
    if (!drive) dq_o = ~last;
    else if (pins_i.id_high_level) dq_o = pins_i.addr[0] ? TYPE_CODE : MAKER_CODE;
    else dq_o = mem[a];
  end
endmodule
`default_nettype wire

//--- otp_program_verify_sequencer_tb.sv
// otp_program_verify_sequencer_tb.sv: corner and random runs of otp_seq against the part model.
// assumes otp_pkg, otp_seq.sv and otp_part_model.sv are compiled first.
`timescale 1ns/10ps
`default_nettype none
module otp_program_verify_sequencer_tb;
  import otp_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] DEVTYPE = 8'hc3; // arbitrary value
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic start_i = 1'b0;
  logic id_req_i = 1'b0;
  logic id_sel_i = 1'b0;
  logic src_valid_i = 1'b0;
  logic erase = 1'b1;
  logic [3:0] need = 4'h1;
  logic [16:0] last_addr_i = 17'h0_0000;
  logic [16:0] cur = 17'h0_0000;
  logic [7:0] src_data_i = 8'h00;
  logic [7:0] dq;
  logic src_ready_o;
  otp_pins_t pins_o;
  otp_pins_t q;
  otp_status_t status_o;
  logic [7:0] img_q[$];
  logic [31:0] seed = 32'he1c8_7f10;
  int error_cnt = 0;
  int n_tests = 0;
  int pulses = 0;
  int vreads = 0;
  int rreads = 0;
  int pw = 0;

  otp_seq u_otp_seq (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i), .last_addr_i(last_addr_i),
    .id_req_i(id_req_i), .id_sel_i(id_sel_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
    .src_data_i(src_data_i), .data_i(dq), .pins_o(pins_o), .status_o(status_o));
  otp_part_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DEVTYPE)) u_otp_part_model (.clock_i(clock_i),
    .erase_i(erase), .need_i(need), .pins_i(pins_o), .dq_o(dq));

  initial begin
    forever #25 clock_i = ~clock_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // feeds the source fifo from the image queue
  always @(posedge clock_i) begin
    if (ce_i && src_valid_i && src_ready_o) void'(img_q.pop_front());
    src_valid_i <= (img_q.size() > 0);
    src_data_i <= (img_q.size() > 0) ? img_q[0] : 8'h00;
  end

  // watches the pins toward the part
  always @(posedge clock_i) begin
    q <= pins_o;
    if (!rst_i) begin
      if (pins_o.vpp_high && !q.vpp_high) begin
        chk("start_addr", 32'h0, 32'(pins_o.addr));
        cur <= 17'h0_0000;
      end
      if (!pins_o.program_pulse_n && q.program_pulse_n) begin
        chk("reads_before_pulse", 32'(pulses), 32'(vreads));
        chk("addr_step", 32'h1, 32'(pins_o.addr == cur || pins_o.addr == cur + 17'h1));
        cur <= pins_o.addr;
        pulses <= pulses + 1;
        pw <= 1;
      end else if (!pins_o.program_pulse_n) begin
        chk("pulse_pins", 32'({q.addr, q.data}), 32'({pins_o.addr, pins_o.data}));
        pw <= pw + 1;
      end else if (!q.program_pulse_n) begin
        chk("pulse_width", 32'h1, 32'(pw >= 1900 && pw <= 2100));
      end
      if (q.data_oe_n && !pins_o.data_oe_n) chk("float_first", 32'h1, 32'(pins_o.out_en_n && q.out_en_n));
      if (!pins_o.out_en_n) begin
        chk("read_pins", 32'h1, 32'(pins_o.program_pulse_n && !pins_o.chip_sel_n && pins_o.data_oe_n));
        // readback keeps the output enable low and steps the address, so each new address is one read
        if (!pins_o.id_high_level && (q.out_en_n || pins_o.addr != q.addr)) begin
          if (pins_o.vpp_high) vreads <= vreads + 1;
          else rreads <= rreads + 1;
        end
      end
    end
  end

  task automatic id_read(input logic sel);
    @(posedge clock_i);
    id_sel_i <= sel;
    id_req_i <= 1'b1;
    @(posedge clock_i);
    id_req_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("id_pins", 32'({1'b1, sel}), 32'({pins_o.id_high_level, pins_o.addr[0]}));
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk("id_valid", 32'h1, 32'(status_o.id_valid));
    chk("id_code", 32'(sel ? DEVTYPE : MAKER), 32'(status_o.id_code));
  endtask

  // bad: index of the readback copy byte that is corrupted, -1 for none
  task automatic run(input logic [16:0] last, input logic [3:0] nd, input int bad);
    logic [7:0] img [8];
    logic [31:0] r;
    logic ok;
    int p0;
    int r0;
    int k;
    ok = (nd < 4'hc) && (bad < 0);
    @(posedge clock_i);
    rst_i <= 1'b1;
    erase <= 1'b1;
    img_q.delete();
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    erase <= 1'b0;
    ce_i <= 1'b0;
    need <= nd;
    last_addr_i <= last;
    for (k = 0; k <= int'(last); k++) begin
      r = rnd();
      img[k] = r[7:0] & 8'hfe;
      img_q.push_back(img[k]);
    end
    for (k = 0; k <= int'(last); k++) img_q.push_back(img[k] ^ ((k == bad) ? 8'h01 : 8'h00));
    p0 = pulses;
    r0 = rreads;
    // with the enable low the fifo must stay frozen in its not-ready reset state
    repeat (8) @(negedge clock_i);
    chk("ce_freeze", 32'h0, 32'(src_ready_o));
    @(posedge clock_i);
    ce_i <= 1'b1;
    repeat (24) @(posedge clock_i);
    if (last == 17'h0_0007) chk("fifo_full", 32'h0, 32'(src_ready_o));
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    @(negedge clock_i);
    chk("busy", 32'h1, 32'(status_o.busy));
    for (k = 0; k < 40000 && status_o.done !== 1'b1; k++) @(negedge clock_i);
    chk("done", 32'h1, 32'(status_o.done));
    chk("busy_end", 32'h0, 32'(status_o.busy));
    chk("pass", 32'(ok), 32'(status_o.pass));
    chk("fail", 32'(!ok), 32'(status_o.fail));
    if (!ok) chk("fail_addr", (nd < 4'hc) ? 32'(bad) : 32'h0, 32'(status_o.fail_addr));
    chk("pulses", (nd < 4'hc) ? (32'(last) + 1) * nd : 32'd11, 32'(pulses - p0));
    if (nd < 4'hc) chk("readbacks", 32'(last) + 1, 32'(rreads - r0));
  endtask

  initial begin
    logic [31:0] r;
    logic [16:0] l;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    erase <= 1'b0;
    repeat (2) @(posedge clock_i);
    id_read(1'b0);
    id_read(1'b1);
    run(17'h0_0000, 4'hb, -1);
    run(17'h0_0000, 4'hc, -1);
    run(17'h0_0007, 4'h1, -1);
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      l = (r[1:0] == 2'h3) ? 17'h0_0002 : {15'h0000, r[1:0]};
      run(l, {3'h0, r[2]} + 4'h1, (i == 0) ? -1 : int'(r[3] ? 17'h0_0000 : l));
    end
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
